/* File: hw/dpit_consts.svh */
// Purpose: Offsets, field positions, reset values of the PHY timing block
// Assumes: Byte addresses on a 32-bit classic Wishbone slave
// Notes:   Definitions only
`ifndef DPIT_CONSTS_SVH
`define DPIT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register word indices (byte address bits 7:2)
// ----------------------------------------------------------------------
`define DPIT_OFS_CAL_LEVEL   6'h00
`define DPIT_OFS_INIT_A      6'h01
`define DPIT_OFS_INIT_B      6'h02
`define DPIT_OFS_CTRL        6'h03
`define DPIT_OFS_STATUS      6'h04

// ----------------------------------------------------------------------
// Writable masks; everything else is reserved and reads zero
// ----------------------------------------------------------------------
`define DPIT_CAL_MASK        32'h000fffff
`define DPIT_INIT_A_MASK     32'h1fffffff
`define DPIT_INIT_B_MASK     32'h0fffffff

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DPIT_CAL_RST         32'h00083def
`define DPIT_CKE_HIGH_RST    9'h180
`define DPIT_CKE_LOW_RST     20'h82536
`define DPIT_ZQ_RST          10'h2ab
`define DPIT_RST_LOW_RST     18'h34156

// ----------------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------------
`define DPIT_CTRL_INIT_GO    0
`define DPIT_CTRL_CAL_GO     1
`define DPIT_CTRL_WL_LOAD    2
`define DPIT_CTRL_DLY_LSB    8
`define DPIT_DLY_W           8

`endif

/* File: hw/dpit_pkg.sv */
// Purpose: Types shared by the PHY timing block
// Assumes: Constants live in dpit_consts.svh
// Notes:   Bus signals travel as packed structs
`default_nettype none
package dpit_pkg;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } dpit_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } dpit_wb_rsp_s;

    typedef enum logic [2:0] {
        CAL_IDLE  = 3'h0,
        CAL_ON    = 3'h1,
        CAL_HOLD  = 3'h2,
        CAL_SETUP = 3'h3,
        CAL_RUN   = 3'h4
    } dpit_cal_e;

    typedef enum logic [2:0] {
        INI_IDLE    = 3'h0,
        INI_RST_LOW = 3'h1,
        INI_CKE_LOW = 3'h2,
        INI_CKE_HI  = 3'h3,
        INI_ZQ_WAIT = 3'h4,
        INI_DONE    = 3'h5
    } dpit_init_e;

    typedef enum logic [0:0] {
        WL_IDLE   = 1'h0,
        WL_SETTLE = 1'h1
    } dpit_wl_e;
endpackage
`default_nettype wire

/* File: hw/dpit_timing.sv */
// Purpose: PHY timing registers and the sequencers they steer
// Assumes: One 200 MHz clock; DRAM-clock counts also run on core_clk
// Notes:   Counts 0 and 1 both give one cycle; the CKE-high field gets one added first
// Function
// [RL1] Wait leveling settle count before DQS high
// [RL2] Wait hold count before calibration go
// [RL3] Wait setup count before gate reasserts
// [RL4] Gate on for exactly calibration-on count
// [RL5] Hold CKE low for programmed count
// [RL6] After CKE high wait count plus one
// [RL7] Hold DRAM reset low for programmed count
// [RL8] After ZQ init wait programmed count
// [RL9] Software computes counts for 533 MHz clocks
// [RL10] Reserved bits read zero, ignore writes
//
// The Wishbone register port and the register addresses were decided locally.
`include "dpit_consts.svh"
`default_nettype none
module dpit_timing #(
    parameter logic [19:0] CKE_LOW_RESET = `DPIT_CKE_LOW_RST,
    parameter logic [17:0] RST_LOW_RESET = `DPIT_RST_LOW_RST,
    parameter int          DLY_W         = `DPIT_DLY_W
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire dpit_pkg::dpit_wb_req_s wb_req,
    output var  dpit_pkg::dpit_wb_rsp_s wb_rsp,
    output var  logic                  dram_reset_n,
    output var  logic                  dram_cke,
    output var  logic                  zq_init_cmd,
    output var  logic                  init_done,
    output var  logic                  cal_clk_en,
    output var  logic                  cal_en,
    output var  logic [DLY_W-1:0]      local_delay_line,
    output var  logic                  dqs_drive
);
    // Delay field lives in control bits [15:8]
    if (DLY_W < 1 || DLY_W > 8) begin : g_bad_dly_w
        $error("DLY_W must lie in 1..8");
    end

    function automatic logic cnt_end(input logic [19:0] c);
        return c <= 20'h00001;
    endfunction

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    logic [31:0] cal_r, init_a_r, init_b_r;
    logic [DLY_W-1:0] dly_r;
    logic        ack_r;
    logic [31:0] rdat_r;
    dpit_pkg::dpit_cal_e  cal_st_r, cal_st_nxt;
    dpit_pkg::dpit_init_e ini_st_r, ini_st_nxt;
    dpit_pkg::dpit_wl_e   wl_st_r, wl_st_nxt;

    wire        req     = wb_req.cyc & wb_req.stb & ~ack_r;
    wire        wr      = req & wb_req.we;
    wire [5:0]  idx     = wb_req.adr[7:2];
    wire [31:0] bmask   = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                           {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
    wire        wr_cal  = wr && idx == `DPIT_OFS_CAL_LEVEL;
    wire        wr_ia   = wr && idx == `DPIT_OFS_INIT_A;
    wire        wr_ib   = wr && idx == `DPIT_OFS_INIT_B;
    wire        wr_ctl  = wr && idx == `DPIT_OFS_CTRL;
    wire [31:0] ctl_d   = wb_req.dat & bmask;
    wire        go_init = wr_ctl && ctl_d[`DPIT_CTRL_INIT_GO];
    wire        go_cal  = wr_ctl && ctl_d[`DPIT_CTRL_CAL_GO];
    wire        go_wl   = wr_ctl && ctl_d[`DPIT_CTRL_WL_LOAD];
    wire [31:0] status  = {22'h0, wl_st_r == dpit_pkg::WL_SETTLE,
                           dqs_drive, cal_st_r != dpit_pkg::CAL_IDLE,
                           cal_en, cal_clk_en, init_done, ini_st_r, 1'b0};
    wire [31:0] ctl_rd  = {16'h0, 8'(dly_r), 8'h0};
    // Unmapped words answer with zero
    wire [31:0] rd_mux  =
        idx == `DPIT_OFS_CAL_LEVEL ? cal_r    :
        idx == `DPIT_OFS_INIT_A    ? init_a_r :
        idx == `DPIT_OFS_INIT_B    ? init_b_r :
        idx == `DPIT_OFS_CTRL      ? ctl_rd   :
        idx == `DPIT_OFS_STATUS    ? status   : 32'h0;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] fmask);
        return ((old & ~bmask) | (wb_req.dat & bmask)) & fmask;
    endfunction

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_r    <= 1'b0;
            rdat_r   <= 32'h0;
            cal_r    <= `DPIT_CAL_RST;
            init_a_r <= {3'h0, `DPIT_CKE_HIGH_RST, CKE_LOW_RESET};
            init_b_r <= {4'h0, `DPIT_ZQ_RST, RST_LOW_RESET};
            dly_r    <= '0;
        end else begin
            ack_r  <= req;
            rdat_r <= req ? rd_mux : 32'h0;
            if (wr_cal) cal_r    <= merge(cal_r, `DPIT_CAL_MASK);    // RL10
            if (wr_ia)  init_a_r <= merge(init_a_r, `DPIT_INIT_A_MASK);
            if (wr_ib)  init_b_r <= merge(init_b_r, `DPIT_INIT_B_MASK);
            if (go_wl)  dly_r    <= ctl_d[`DPIT_CTRL_DLY_LSB +: DLY_W];
        end
    end
    assign wb_rsp = '{ack: ack_r, dat: rdat_r};

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    wire [19:0] t_wl    = {15'h0, cal_r[19:15]};
    wire [19:0] t_hold  = {15'h0, cal_r[14:10]};
    wire [19:0] t_setup = {15'h0, cal_r[9:5]};
    wire [19:0] t_on    = {15'h0, cal_r[4:0]};
    wire [19:0] t_cke_l = init_a_r[19:0];
    wire [19:0] t_cke_h = {11'h0, init_a_r[28:20]} + 20'h00001;
    wire [19:0] t_rst_l = {2'h0, init_b_r[17:0]};
    wire [19:0] t_zq    = {10'h0, init_b_r[27:18]};

    // ------------------------------------------------------------------
    // Calibration gate and go sequencer
    // ------------------------------------------------------------------
    logic [19:0] cal_cnt_r, cal_cnt_nxt;
    always_comb begin
        cal_st_nxt  = cal_st_r;
        cal_cnt_nxt = cal_cnt_r - 20'h00001;
        unique case (cal_st_r)
            dpit_pkg::CAL_IDLE: begin
                if (go_cal) begin
                    cal_st_nxt  = dpit_pkg::CAL_ON;
                    cal_cnt_nxt = t_on;
                end
            end
            dpit_pkg::CAL_ON: begin
                if (cnt_end(cal_cnt_r)) begin                        // RL4
                    cal_st_nxt  = dpit_pkg::CAL_HOLD;
                    cal_cnt_nxt = t_hold;
                end
            end
            dpit_pkg::CAL_HOLD: begin
                if (cnt_end(cal_cnt_r)) begin                        // RL2
                    cal_st_nxt  = dpit_pkg::CAL_SETUP;
                    cal_cnt_nxt = t_setup;
                end
            end
            dpit_pkg::CAL_SETUP: begin
                if (cnt_end(cal_cnt_r)) begin                        // RL3
                    cal_st_nxt  = dpit_pkg::CAL_RUN;
                    cal_cnt_nxt = t_on;
                end
            end
            dpit_pkg::CAL_RUN: begin
                if (cnt_end(cal_cnt_r)) begin                        // RL4
                    cal_st_nxt  = dpit_pkg::CAL_IDLE;
                end
            end
            default: cal_st_nxt = dpit_pkg::CAL_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cal_st_r   <= dpit_pkg::CAL_IDLE;
            cal_cnt_r  <= 20'h0;
            cal_clk_en <= 1'b0;
            cal_en     <= 1'b0;
        end else begin
            cal_st_r   <= cal_st_nxt;
            cal_cnt_r  <= cal_cnt_nxt;
            cal_clk_en <= cal_st_nxt == dpit_pkg::CAL_ON ||
                          cal_st_nxt == dpit_pkg::CAL_RUN;
            cal_en     <= cal_st_nxt == dpit_pkg::CAL_SETUP ||
                          cal_st_nxt == dpit_pkg::CAL_RUN;
        end
    end

    // ------------------------------------------------------------------
    // Write-leveling settle
    // ------------------------------------------------------------------
    logic [19:0] wl_cnt_r;
    always_comb begin
        wl_st_nxt = wl_st_r;
        unique case (wl_st_r)
            dpit_pkg::WL_IDLE:   if (go_wl) wl_st_nxt = dpit_pkg::WL_SETTLE;
            dpit_pkg::WL_SETTLE: begin
                // A reload restarts the settle window
                if (cnt_end(wl_cnt_r) && !go_wl) begin               // RL1
                    wl_st_nxt = dpit_pkg::WL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wl_st_r          <= dpit_pkg::WL_IDLE;
            wl_cnt_r         <= 20'h0;
            dqs_drive        <= 1'b0;
            local_delay_line <= '0;
        end else begin
            wl_st_r          <= wl_st_nxt;
            wl_cnt_r         <= go_wl ? t_wl : wl_cnt_r - 20'h00001;
            local_delay_line <= go_wl ? ctl_d[`DPIT_CTRL_DLY_LSB +: DLY_W]
                                      : local_delay_line;
            // DQS held low while the delay line settles
            if (go_wl) dqs_drive <= 1'b0;
            else if (wl_st_r == dpit_pkg::WL_SETTLE &&
                     wl_st_nxt == dpit_pkg::WL_IDLE) dqs_drive <= 1'b1; // RL1
        end
    end

    // ------------------------------------------------------------------
    // DRAM power-up initialization
    // ------------------------------------------------------------------
    logic [19:0] ini_cnt_r, ini_cnt_nxt;
    always_comb begin
        ini_st_nxt  = ini_st_r;
        ini_cnt_nxt = ini_cnt_r - 20'h00001;
        unique case (ini_st_r)
            dpit_pkg::INI_IDLE, dpit_pkg::INI_DONE: begin
                if (go_init) begin
                    ini_st_nxt  = dpit_pkg::INI_RST_LOW;
                    ini_cnt_nxt = t_rst_l;
                end
            end
            dpit_pkg::INI_RST_LOW: begin
                if (cnt_end(ini_cnt_r)) begin                        // RL7
                    ini_st_nxt  = dpit_pkg::INI_CKE_LOW;
                    ini_cnt_nxt = t_cke_l;
                end
            end
            dpit_pkg::INI_CKE_LOW: begin
                if (cnt_end(ini_cnt_r)) begin                        // RL5
                    ini_st_nxt  = dpit_pkg::INI_CKE_HI;
                    ini_cnt_nxt = t_cke_h;
                end
            end
            dpit_pkg::INI_CKE_HI: begin
                if (cnt_end(ini_cnt_r)) begin                        // RL6
                    ini_st_nxt  = dpit_pkg::INI_ZQ_WAIT;
                    ini_cnt_nxt = t_zq;
                end
            end
            dpit_pkg::INI_ZQ_WAIT: begin
                if (cnt_end(ini_cnt_r)) begin                        // RL8
                    ini_st_nxt  = dpit_pkg::INI_DONE;
                end
            end
            default: ini_st_nxt = dpit_pkg::INI_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ini_st_r     <= dpit_pkg::INI_IDLE;
            ini_cnt_r    <= 20'h0;
            dram_reset_n <= 1'b0;
            dram_cke     <= 1'b0;
            zq_init_cmd  <= 1'b0;
            init_done    <= 1'b0;
        end else begin
            ini_st_r     <= ini_st_nxt;
            ini_cnt_r    <= ini_cnt_nxt;
            dram_reset_n <= ini_st_nxt != dpit_pkg::INI_RST_LOW &&
                            ini_st_nxt != dpit_pkg::INI_IDLE;        // RL7
            dram_cke     <= ini_st_nxt == dpit_pkg::INI_CKE_HI ||
                            ini_st_nxt == dpit_pkg::INI_ZQ_WAIT ||
                            ini_st_nxt == dpit_pkg::INI_DONE;        // RL5
            zq_init_cmd  <= ini_st_r == dpit_pkg::INI_CKE_HI &&
                            ini_st_nxt == dpit_pkg::INI_ZQ_WAIT;     // RL6
            init_done    <= ini_st_nxt == dpit_pkg::INI_DONE;        // RL8
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_wl_settle_low: assert property ( // RL1
        wl_st_r == dpit_pkg::WL_SETTLE |-> !dqs_drive)
        else $error("DQS driven during settle");
    a_wl_settle_end: assert property ( // RL1
        wl_st_r == dpit_pkg::WL_SETTLE && cnt_end(wl_cnt_r) && !go_wl
        |=> dqs_drive && wl_st_r == dpit_pkg::WL_IDLE)
        else $error("DQS not raised after settle");
    a_cal_hold_gap: assert property ( // RL2
        cal_st_r == dpit_pkg::CAL_HOLD |-> !cal_clk_en && !cal_en)
        else $error("Gate or go active in hold");
    a_cal_go_rise: assert property ( // RL2
        $rose(cal_en)
        |-> !cal_clk_en ##0 $past(cal_st_r) == dpit_pkg::CAL_HOLD)
        else $error("Go rose outside hold exit");
    a_cal_on_len: assert property ( // RL4
        cal_st_r == dpit_pkg::CAL_ON && cal_cnt_r == 20'h2
        |-> cal_clk_en ##1 cal_clk_en ##1 !cal_clk_en)
        else $error("Gate on time wrong");
    a_cke_low_hold: assert property ( // RL5
        ini_st_r == dpit_pkg::INI_CKE_LOW |-> !dram_cke && dram_reset_n)
        else $error("CKE not low after reset release");
    a_cke_hi_wait: assert property ( // RL6
        // A zero field legally allows the command one cycle after CKE
        $rose(dram_cke) && init_a_r[28:20] != 9'h0
        |-> !zq_init_cmd [*2])
        else $error("Command too soon after CKE");
    a_rst_low_hold: assert property ( // RL7
        ini_st_r == dpit_pkg::INI_RST_LOW && ini_cnt_r == 20'h3
        |-> !dram_reset_n [*3] ##1 dram_reset_n)
        else $error("Reset low time wrong");
    a_zq_wait_done: assert property ( // RL8
        zq_init_cmd |-> !init_done ##1 !zq_init_cmd)
        else $error("Done too soon after ZQ");
    a_rsvd_read_zero: assert property ( // RL10
        req && !wb_req.we && idx == `DPIT_OFS_CAL_LEVEL
        |=> wb_rsp.ack && wb_rsp.dat[31:20] == 12'h0)
        else $error("Reserved bits read non-zero");

    c_init_done: cover property ($rose(init_done));
    c_cal_full:  cover property ($fell(cal_en));
    c_wl_dqs:    cover property ($rose(dqs_drive));
endmodule // dpit_timing
`default_nettype wire

/* File: bench/dpit_dram_model.sv */
// Purpose: Behavioural DRAM side of the power-up sequence
// Assumes: Init pins are registered on core_clk
// Notes:   Reports the length of the last run of each init phase
`default_nettype none
module dpit_dram_model (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic dram_reset_n,
    input  wire logic dram_cke,
    input  wire logic zq_init_cmd,
    input  wire logic init_done,
    output var  int   rst_low_n,
    output var  int   cke_low_n,
    output var  int   cke_hi_n,
    output var  int   zq_n,
    output var  logic proto_err
);
    timeunit 1ns;
    timeprecision 1ps;
    int   rl_c;
    int   cl_c;
    int   ch_c;
    int   zq_c;
    logic zq_on;

    // ------------------------------------------------------------------
    // Phase run counters
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            rl_c = 0;
            cl_c = 0;
            ch_c = 0;
            zq_c = 0;
            zq_on = 1'b0;
            proto_err = 1'b0;
            rst_low_n = 0;
            cke_low_n = 0;
            cke_hi_n = 0;
            zq_n = 0;
        end else begin
            if (!dram_reset_n) rl_c++;
            else if (rl_c != 0) begin
                rst_low_n = rl_c;
                rl_c = 0;
            end
            if (dram_reset_n && !dram_cke) cl_c++;
            else if (cl_c != 0) begin
                cke_low_n = cl_c;
                cl_c = 0;
            end
            if (zq_init_cmd) begin
                cke_hi_n = ch_c;
                ch_c = 0;
                zq_on = 1'b1;
                zq_c = 1;
            end else if (zq_on && init_done) begin
                zq_n = zq_c;
                zq_on = 1'b0;
            end else if (zq_on) zq_c++;
            else if (dram_cke && !init_done) ch_c++;
            // A command with the part held in reset or CKE low is lost
            if (zq_init_cmd && !(dram_reset_n && dram_cke)) begin
                proto_err = 1'b1;
            end
            if (init_done && !dram_reset_n) proto_err = 1'b1;
        end
    end
endmodule // dpit_dram_model
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: Self-checking bench for the PHY timing block
// Assumes: Short reset-time parameters keep the run brief
// Notes:   Outputs are read at each edge, ahead of that edge's updates
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] CKE_LOW = 20'h10;
    localparam logic [17:0] RST_LOW = 18'h8;
    logic                   core_clk;
    logic                   rst;
    dpit_pkg::dpit_wb_req_s wb_req;
    dpit_pkg::dpit_wb_rsp_s wb_rsp;
    logic                   dram_reset_n, dram_cke, zq_init_cmd, init_done;
    logic                   cal_clk_en, cal_en, dqs_drive, proto_err;
    logic [7:0]             local_delay_line;
    int                     rst_low_n, cke_low_n, cke_hi_n, zq_n, n;
    int                     errors = 0;
    int                     n_checks = 0;
    int                     cycles = 0;
    logic [31:0]            q;

    dpit_timing #(.CKE_LOW_RESET(CKE_LOW), .RST_LOW_RESET(RST_LOW)) dut (
        .core_clk(core_clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .dram_reset_n(dram_reset_n), .dram_cke(dram_cke),
        .zq_init_cmd(zq_init_cmd), .init_done(init_done),
        .cal_clk_en(cal_clk_en), .cal_en(cal_en),
        .local_delay_line(local_delay_line), .dqs_drive(dqs_drive));

    dpit_dram_model dram (
        .core_clk(core_clk), .rst(rst), .dram_reset_n(dram_reset_n),
        .dram_cke(dram_cke), .zq_init_cmd(zq_init_cmd),
        .init_done(init_done), .rst_low_n(rst_low_n),
        .cke_low_n(cke_low_n), .cke_hi_n(cke_hi_n), .zq_n(zq_n),
        .proto_err(proto_err));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        if (errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge core_clk);
    endtask

    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        @(posedge core_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr,
                    dat: dat};
        // No latency assumed; the wait ends on ack, and only the hang guard bounds it
        do begin
            @(posedge core_clk);
        end while (wb_rsp.ack !== 1'b1);
        q = wb_rsp.dat;
        wb_req <= '0;
        chk({31'h0, wb_rsp.ack}, 32'h1);
    endtask

    function automatic logic cond(input int k);
        case (k)
            0: return cal_clk_en;
            1: return !cal_clk_en && !cal_en;
            2: return cal_en && !cal_clk_en;
            3: return !dqs_drive;
            4: return dqs_drive;
            default: return init_done;
        endcase
    endfunction

    task automatic wait_for(input int k);
        for (int i = 0; i < 4000 && cond(k) !== 1'b1; i++) step();
    endtask

    task automatic run(input int k, output int cnt);
        cnt = 0;
        while (cond(k) === 1'b1 && cnt < 4000) begin
            step();
            cnt++;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        wb(1'b0, 8'h00, 32'h0);
        chk(q, {12'h0, 5'h10, 5'hf, 5'hf, 5'hf});
        wb(1'b0, 8'h04, 32'h0); chk(q, {3'h0, 9'h180, CKE_LOW});
        wb(1'b0, 8'h08, 32'h0); chk(q, {4'h0, 10'h2ab, RST_LOW});
    endtask

    task automatic t_reserved();
        wb(1'b1, 8'h00, 32'hffffffff);
        wb(1'b0, 8'h00, 32'h0); chk(q, 32'h000fffff);
        wb(1'b1, 8'h04, 32'hffffffff);
        wb(1'b0, 8'h04, 32'h0); chk(q, 32'h1fffffff);
        wb(1'b1, 8'h08, 32'hffffffff);
        wb(1'b0, 8'h08, 32'h0); chk(q, 32'h0fffffff);
        wb(1'b1, 8'h20, 32'hffffffff);
        wb(1'b0, 8'h20, 32'h0); chk(q, 32'h0);
    endtask

    task automatic t_init();
        // Short counts; real parts scale them for 533 MHz clocks
        wb(1'b1, 8'h04, 32'h00200005);
        wb(1'b1, 8'h08, 32'h00100003);
        wb(1'b1, 8'h0c, 32'h00000001);
        wait_for(5);
        // Second start from done gives clean edges on every phase
        wb(1'b1, 8'h0c, 32'h00000001);
        step();
        chk({31'h0, init_done}, 32'h0);
        wait_for(5);
        chk({31'h0, init_done}, 32'h1);
        // Model latches the ZQ run on the edge that shows done
        step();
        chk(rst_low_n, 3);
        chk(cke_low_n, 5);
        chk(cke_hi_n, 3);
        chk(zq_n, 4);
        chk({31'h0, proto_err}, 32'h0);
        wb(1'b0, 8'h10, 32'h0); chk(q & 32'h10, 32'h10);
    endtask

    task automatic t_cal();
        wb(1'b1, 8'h00, 32'h000310a3);
        wb(1'b1, 8'h0c, 32'h00000002);
        wait_for(0);
        run(0, n); chk(n, 3);
        run(1, n); chk(n, 4);
        run(2, n); chk(n, 5);
        chk({31'h0, cal_en}, 32'h1);
        run(0, n); chk(n, 3);
        chk({31'h0, cal_en}, 32'h0);
        // Zero on-count still opens the gate for one cycle
        wb(1'b1, 8'h00, 32'h000310a0);
        wb(1'b1, 8'h0c, 32'h00000002);
        wait_for(0);
        run(0, n); chk(n, 1);
    endtask

    task automatic t_level();
        wb(1'b1, 8'h0c, 32'h0000a504);
        wait_for(4);
        wb(1'b1, 8'h0c, 32'h00005a04);
        chk(local_delay_line, 32'h5a);
        wait_for(3);
        run(3, n); chk(n, 6);
        chk({31'h0, dqs_drive}, 32'h1);
        wb(1'b0, 8'h0c, 32'h0); chk(q, 32'h00005a00);
    endtask

    // ------------------------------------------------------------------
    // Hang guard and main sequence
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    initial begin
        rst = 1'b1;
        wb_req = '0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_reserved();
        t_init();
        t_cal();
        t_level();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
